// ==== src/crc32_word_accumulator.sv ====
// Purpose: Running CRC-32 over 32-bit words, with reload control and a scratch byte.
// Assumes: All inputs come from logic on sys_clk_in; no register bus, plain ports only.
// Notes: A 4-word queue absorbs bursts; its ready, closed while a reload is pending, is the hold-off seen by the writer.
`timescale 1ns/1ps
module crc32_word_accumulator (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Data word writes
    input wire logic word_valid_in,
    input wire logic [crc32_pkg::WORD_W-1:0] word_in,
    output logic word_ready_out,
    // Checksum result
    output logic [crc32_pkg::WORD_W-1:0] checksum_out,
    // Control word writes
    input wire logic control_wr_in,
    input wire logic [crc32_pkg::WORD_W-1:0] control_in,
    // Scratch byte
    input wire crc32_pkg::scratch_wr_t scratch_in,
    output logic [crc32_pkg::SCRATCH_W-1:0] scratch_out,
    // Status
    output crc32_pkg::crc_status_t status_out
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FOLD,
        ST_RELOAD
    } acc_state_t;

    acc_state_t state_q;
    acc_state_t state_d;
    logic [crc32_pkg::WORD_W-1:0] acc_q;
    logic [crc32_pkg::SCRATCH_W-1:0] scratch_q;
    logic reload_q;

    // Queue and engine wiring
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [crc32_pkg::WORD_W-1:0] fifo_out_data;
    logic [2:0] fifo_level;
    logic eng_busy;
    logic eng_done;
    logic [crc32_pkg::WORD_W-1:0] eng_result;

    // A pending reload closes the input so words written before it are folded first
    wire fifo_push_ok = fifo_in_ready && !reload_q;
    wire reload_req = control_wr_in && control_in[crc32_pkg::CTRL_RELOAD_BIT];
    // Queued words still drain while a reload waits, otherwise the reload would never run
    wire take_word = (state_q == ST_IDLE) && !eng_busy && fifo_out_valid;
    wire do_reload = (state_q == ST_IDLE) && reload_q && !fifo_out_valid;

    assign word_ready_out = fifo_push_ok; // R10
    assign checksum_out = acc_q; // R3 R7
    assign scratch_out = scratch_q;
    assign status_out = '{reload_pending: reload_q, busy: (state_q != ST_IDLE), fifo_level: fifo_level};

    word_fifo #(
        .WIDTH(crc32_pkg::WORD_W),
        .DEPTH(crc32_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .in_valid_in(word_valid_in && !reload_q),
        .in_data_in(word_in),
        .in_ready_out(fifo_in_ready),
        .out_valid_out(fifo_out_valid),
        .out_data_out(fifo_out_data),
        .out_ready_in(take_word),
        .level_out(fifo_level)
    );

    // Writes go to the fold, never straight into the accumulator
    crc_fold_engine u_engine (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .start_in(take_word), // R2 R6
        .seed_in(acc_q), // R8
        .word_in(fifo_out_data),
        .busy_out(eng_busy),
        .done_out(eng_done),
        .result_out(eng_result)
    );

    // Next state: the engine holds off the queue until its result lands
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (take_word) begin
                    state_d = ST_FOLD;
                end else if (do_reload) begin
                    state_d = ST_RELOAD;
                end
            end
            ST_FOLD: begin
                if (eng_done) begin
                    state_d = ST_IDLE; // R10
                end
            end
            ST_RELOAD: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Accumulator: result commits on done; reload presets all ones
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            acc_q <= crc32_pkg::CHECKSUM_RESET;
        end else if ((state_q == ST_FOLD) && eng_done) begin
            acc_q <= eng_result; // R5 R7
        end else if (state_q == ST_RELOAD) begin
            acc_q <= crc32_pkg::CHECKSUM_RELOAD; // R11
        end
    end

    // Reload bit: software only sets it; a new set in the clearing cycle wins
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            reload_q <= 1'b0;
        end else if (reload_req) begin
            reload_q <= 1'b1; // R13
        end else if (state_q == ST_RELOAD) begin
            reload_q <= 1'b0; // R13
        end
    end

    // Scratch byte is touched only by its own write and by system reset
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            scratch_q <= crc32_pkg::SCRATCH_RESET; // R14
        end else if (scratch_in.wr) begin
            scratch_q <= scratch_in.data; // R4 R12
        end
    end

endmodule

// ==== src/crc32_pkg.sv ====
// Purpose: Shared constants, types and the word-wide checksum fold for the CRC-32 accumulator.
// Assumes: One 40 MHz clock (25 ns), synchronous active-high reset.
// Notes: All producers and consumers of the accumulator sit on the same clock.
// How it works
// R1 - Checksum uses generator polynomial 0x4C11DB7, the Ethernet CRC-32.
// R2 - Input arrives as whole 32-bit words from the bus master.
// R3 - One 32-bit location takes data in and gives the checksum out.
// R4 - An extra 8-bit scratch register stores a byte, no checksum effect.
// R5 - Each word's checksum update completes within four clock cycles.
// R6 - Writing the data location feeds the word into the checksum, not storage.
// R7 - Reading the data location returns the last completed checksum.
// R8 - Each word folds into the previous checksum, forming a running checksum.
// R9 - Each word is folded as one 32-bit unit, not byte by byte.
// R10 - Further writes are held off while a computation is running; here a 4-word queue takes them, held off only when full or a reload is pending.
// R11 - Setting the reload control bit loads the checksum with all ones.
// R12 - The reload leaves the scratch byte unchanged.
// R13 - Reload bit is control bit 0, set by software, cleared by hardware.
// R14 - Scratch byte sits in bits 7:0, read/write, zero after reset.
// R15 - Bits enter most significant first, no reflection, no final inversion.
package crc32_pkg;

    localparam int WORD_W = 32;
    localparam int SCRATCH_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int COUNT_W = 2;

    // Generator and preset values
    localparam logic [WORD_W-1:0] CRC_POLY = 32'h04C11DB7;
    localparam logic [WORD_W-1:0] CHECKSUM_RESET = 32'hFFFFFFFF;
    localparam logic [WORD_W-1:0] CHECKSUM_RELOAD = 32'hFFFFFFFF;
    localparam logic [SCRATCH_W-1:0] SCRATCH_RESET = 8'h00;

    // Control word layout
    localparam int CTRL_RELOAD_BIT = 0;

    // Cycle budget of one fold, counted from the accept edge to the visible result
    localparam int COMPUTE_CYCLES = 4;
    localparam logic [COUNT_W-1:0] COUNT_LOAD = COUNT_W'(COMPUTE_CYCLES - 2);
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 2'h0;

    // Status bundle shown to the outside
    typedef struct packed {
        logic reload_pending;
        logic busy;
        logic [2:0] fifo_level;
    } crc_status_t;

    // Scratch byte write bundle
    typedef struct packed {
        logic wr;
        logic [SCRATCH_W-1:0] data;
    } scratch_wr_t;

    // Whole-word fold, MSB first, no reflection, no final inversion
    function automatic logic [WORD_W-1:0] crc_fold(input logic [WORD_W-1:0] acc, input logic [WORD_W-1:0] word);
        logic [WORD_W-1:0] c;
        logic fb;
        c = acc;
        fb = 1'b0;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            fb = c[WORD_W-1] ^ word[i];
            c = {c[WORD_W-2:0], 1'b0};
            if (fb) begin
                c = c ^ CRC_POLY;
            end
        end
        return c;
    endfunction

endpackage

// ==== src/word_fifo.sv ====
// Purpose: Small synchronous FIFO in front of the checksum engine.
// Assumes: Same clock on both sides; synchronous active-high reset.
// Notes: Output data come from a register so the consumer sees a stable word.
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in,
    // Occupancy
    output logic [$clog2(DEPTH+1)-1:0] level_out
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int LVL_W = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [LVL_W-1:0] level_q;
    logic [WIDTH-1:0] head_q;
    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;

    // Honest flags straight from the occupancy count
    assign in_ready_out = (level_q != LVL_W'(DEPTH));
    assign out_valid_out = (level_q != '0);
    assign level_out = level_q;
    assign out_data_out = head_q;

    // Storage and pointers
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            level_q <= '0;
        end else begin
            if (push) begin
                mem_q[wr_ptr_q] <= in_data_in;
                wr_ptr_q <= PTR_W'(wr_ptr_q + 1'b1);
            end
            if (pop) begin
                rd_ptr_q <= PTR_W'(rd_ptr_q + 1'b1);
            end
            level_q <= LVL_W'(level_q + LVL_W'(push) - LVL_W'(pop));
        end
    end

    // Registered head word; bypasses the array when the head is being written now
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            head_q <= '0;
        end else if (push && (level_q == LVL_W'(pop)) ) begin
            head_q <= in_data_in;
        end else if (pop) begin
            head_q <= mem_q[PTR_W'(rd_ptr_q + 1'b1)];
        end else begin
            head_q <= mem_q[rd_ptr_q];
        end
    end
endmodule

// ==== src/crc_fold_engine.sv ====
// Purpose: Folds one 32-bit word into a seed value and paces the result to the cycle budget.
// Assumes: start_in only while busy_out is low.
// Notes: The fold is one wide combinational step; the counter only paces it.
`timescale 1ns/1ps
module crc_fold_engine (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Request
    input wire logic start_in,
    input wire logic [crc32_pkg::WORD_W-1:0] seed_in,
    input wire logic [crc32_pkg::WORD_W-1:0] word_in,
    // Answer
    output logic busy_out,
    output logic done_out,
    output logic [crc32_pkg::WORD_W-1:0] result_out
);
    logic [crc32_pkg::WORD_W-1:0] result_q;
    logic [crc32_pkg::COUNT_W-1:0] count_q;
    logic busy_q;
    wire [crc32_pkg::WORD_W-1:0] folded = crc32_pkg::crc_fold(seed_in, word_in); // R1 R9 R15

    assign busy_out = busy_q;
    assign done_out = busy_q && (count_q == crc32_pkg::COUNT_ZERO);
    assign result_out = result_q;

    // Capture the folded word at start, then count down to the done cycle
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            busy_q <= 1'b0;
            count_q <= crc32_pkg::COUNT_ZERO;
            result_q <= crc32_pkg::CHECKSUM_RESET;
        end else if (start_in) begin
            busy_q <= 1'b1;
            count_q <= crc32_pkg::COUNT_LOAD; // R5
            result_q <= folded; // R8
        end else if (done_out) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            count_q <= crc32_pkg::COUNT_W'(count_q - 1'b1);
        end
    end
endmodule

// ==== test/crc32_acc_sva.sv ====
// Purpose: Port-level timing and value checks for the CRC-32 accumulator.
// Assumes: One clock, synchronous active-high reset.
// Notes: Sees only the top module's ports.
`timescale 1ns/1ps
module crc32_acc_sva (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Word path
    input wire logic word_valid_in,
    input wire logic [crc32_pkg::WORD_W-1:0] word_in,
    input wire logic word_ready_out,
    input wire logic [crc32_pkg::WORD_W-1:0] checksum_out,
    // Control, scratch and status
    input wire logic control_wr_in,
    input wire logic [crc32_pkg::WORD_W-1:0] control_in,
    input wire crc32_pkg::scratch_wr_t scratch_in,
    input wire logic [crc32_pkg::SCRATCH_W-1:0] scratch_out,
    input wire crc32_pkg::crc_status_t status_out
);
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    // Hold-off, acceptance and fold pacing
    chk_ready_rule: assert property (word_ready_out == (status_out.fifo_level != 3'h4 && !status_out.reload_pending))
        else $error("ready disagrees with queue state");
    chk_word_accept: assert property (word_valid_in && word_ready_out |=> status_out.fifo_level != 3'h0)
        else $error("accepted word not queued");
    chk_fold_length: assert property ($rose(status_out.busy) && !$past(status_out.reload_pending) |-> status_out.busy[*3])
        else $error("fold shorter than budget");
    chk_sum_cause: assert property ($changed(checksum_out) |-> $past(status_out.busy))
        else $error("checksum moved while idle");
    // Reload control; a reload can wait behind four queued folds
    chk_reload_set: assert property (control_wr_in && control_in[0] |=> status_out.reload_pending)
        else $error("reload request lost");
    chk_reload_done: assert property ($rose(status_out.reload_pending) |-> ##[1:30] !status_out.reload_pending)
        else $error("reload never cleared");
    chk_reload_value: assert property ($fell(status_out.reload_pending) |-> checksum_out == 32'hFFFFFFFF)
        else $error("reload value wrong");
    // Scratch byte
    chk_scratch_write: assert property (scratch_in.wr |=> scratch_out == $past(scratch_in.data))
        else $error("scratch write lost");
    chk_scratch_hold: assert property (!scratch_in.wr |=> $stable(scratch_out))
        else $error("scratch changed without write");
endmodule

bind crc32_word_accumulator crc32_acc_sva u_crc32_acc_sva (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .word_valid_in(word_valid_in), .word_in(word_in), .word_ready_out(word_ready_out), .checksum_out(checksum_out),
    .control_wr_in(control_wr_in), .control_in(control_in), .scratch_in(scratch_in), .scratch_out(scratch_out),
    .status_out(status_out));

// ==== test/word_source.sv ====
// Purpose: Bus-master stand-in offering queued words on valid/ready.
// Assumes: The bench pushes words into pend_q 1 ns after an edge.
// Notes: Idle data flips every cycle so a stale word never looks fresh.
`timescale 1ns/1ps
module word_source (
    // Clock
    input wire logic sys_clk_in,
    // Handshake
    input wire logic ready_in,
    output logic valid_out,
    output logic [31:0] data_out
);
    logic [31:0] pend_q[$];
    initial begin
        valid_out = 1'b0;
        data_out = 32'h00000000;
    end
    // Hold a word until taken; 2 ns so pushes made at 1 ns are seen
    always @(posedge sys_clk_in) begin
        if (valid_out === 1'b1 && ready_in === 1'b1) begin
            void'(pend_q.pop_front());
        end
        #2;
        valid_out = (pend_q.size() != 0);
        data_out = valid_out ? pend_q[0] : ~data_out;
    end
endmodule

// ==== test/crc32_word_accumulator_test.sv ====
// Purpose: Self-checking bench for the CRC-32 word accumulator.
// Assumes: 40 MHz clock; bench inputs move 1 ns after the rising edge.
// Notes: The reference fold is kept here, apart from the design.
`timescale 1ns/1ps
module crc32_word_accumulator_test;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic control_wr = 1'b0;
    logic [31:0] control = 32'h00000000;
    crc32_pkg::scratch_wr_t scratch_wr = '0;
    logic word_valid;
    logic word_ready;
    logic [31:0] word;
    logic [31:0] checksum;
    logic [7:0] scratch;
    crc32_pkg::crc_status_t status;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    logic full_seen;
    logic [31:0] acc;

    crc32_word_accumulator u_crc32_word_accumulator (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .word_valid_in(word_valid), .word_in(word), .word_ready_out(word_ready), .checksum_out(checksum),
        .control_wr_in(control_wr), .control_in(control), .scratch_in(scratch_wr), .scratch_out(scratch),
        .status_out(status));
    word_source u_word_source (.sys_clk_in(sys_clk_in), .ready_in(word_ready), .valid_out(word_valid),
        .data_out(word));

    // 25 ns clock and a hang guard well past the expected run
    always #12.5 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            print_verdict();
        end
    end

    // Bitwise MSB-first fold, no reflection and no final inversion
    function automatic logic [31:0] ref_fold(input logic [31:0] a, input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            a = (a[31] ^ w[i]) ? ({a[30:0], 1'b0} ^ crc32_pkg::CRC_POLY) : {a[30:0], 1'b0};
        end
        return a;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic push(input logic [31:0] w);
        u_word_source.pend_q.push_back(w);
        acc = ref_fold(acc, w);
    endtask

    // Wait until the source, queue, engine and reload are all quiet
    task automatic settle();
        int n;
        n = 0;
        while ((u_word_source.pend_q.size() != 0 || status !== 5'h00) && n < 200) begin
            if (status.fifo_level === 3'h4 && word_ready === 1'b0) full_seen = 1'b1;
            tick(1);
            n++;
        end
        check(32'(n < 200), 32'h00000001);
    endtask

    task automatic t_single();
        acc = 32'hFFFFFFFF;
        check(checksum, acc);
        check(32'(word_ready), 32'h00000001);
        push(32'h12345678);
        tick(4);
        check(checksum, 32'hFFFFFFFF);
        tick(1);
        check(checksum, acc);
    endtask

    task automatic t_stream(input int n);
        full_seen = 1'b0;
        for (int i = 0; i < n; i++) begin
            push(32'hA5000001 + 32'(i) * 32'h01010101);
        end
        settle();
        check(checksum, acc);
        check(32'(full_seen), 32'(n > 4));
    endtask

    task automatic t_scratch();
        scratch_wr = '{wr: 1'b1, data: 8'h5A};
        tick(1);
        check(32'(scratch), 32'h0000005A);
        scratch_wr.data = 8'hC3;
        tick(1);
        scratch_wr.wr = 1'b0;
        check(32'(scratch), 32'h000000C3);
    endtask

    task automatic t_reload();
        int n;
        control = 32'hFFFFFFFE;
        control_wr = 1'b1;
        tick(1);
        control_wr = 1'b0;
        check(32'(status.reload_pending), 32'h00000000);
        push(32'h0000FFFF);
        push(32'h80000000);
        tick(1);
        control = 32'h00000001;
        control_wr = 1'b1;
        tick(1);
        control_wr = 1'b0;
        check(32'(status.reload_pending), 32'h00000001);
        n = 0;
        while (status.reload_pending === 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        check(checksum, 32'hFFFFFFFF);
        acc = 32'hFFFFFFFF;
        push(32'h00000000);
        settle();
        check(checksum, acc);
        check(32'(scratch), 32'h000000C3);
    endtask

    task automatic print_verdict();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        tick(12);
        rst_in = 1'b0;
        t_single();
        settle();
        t_stream(3);
        t_stream(6);
        t_scratch();
        t_reload();
        print_verdict();
    end
endmodule
